// ---- ovr_pkg.sv ----
// Purpose: Shared constants for the overrange monitor and sample marker block
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes:   Every offset, reset value and count is named here once, and every field position except state register bits 0 to 4
package ovr_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] THRESH_ADDR = 8'h04;
  localparam logic [7:0] FRAME_ADDR  = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0C;
  localparam logic [7:0] MASK_ADDR   = 8'h10;
  localparam logic [7:0] STATE_ADDR  = 8'h14;

  // Register field positions
  localparam int CTRL_MARKER_EN  = 0;
  localparam int CTRL_SYSREF_MK  = 1;
  localparam int CTRL_DUAL       = 2;
  localparam int CTRL_HOLD_LSB   = 4;
  localparam int THR_HI_LSB      = 0;
  localparam int THR_LO_LSB      = 8;
  localparam int FRM_DEMUX_LSB   = 0;
  localparam int FRM_LEN_LSB     = 8;
  localparam int STATE_CNT_LSB   = 8;

  // Status bit positions
  localparam int ST_A0     = 0;
  localparam int ST_A1     = 1;
  localparam int ST_B0     = 2;
  localparam int ST_B1     = 3;
  localparam int ST_SYSREF = 4;
  localparam int ST_BITS   = 5;

  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0004;
  localparam logic [31:0] THRESH_RST = 32'h0000_FFFF;
  localparam logic [31:0] FRAME_RST  = 32'h0000_0101;

  // Sample and timing figures
  localparam int          SAMPLE_W    = 12;
  localparam logic [11:0] MOST_NEG    = 12'h800;
  localparam logic [10:0] MAG_MAX     = 11'h7FF;
  localparam logic [10:0] HOLD_BASE   = 11'h008;
  localparam int          SYNC_STAGES = 3;
  localparam int          MARK_LAT    = 4;

endpackage

// ---- ovr_flag_unit.sv ----
// Purpose: Magnitude check of one sample stream against two thresholds
// Assumes: Samples are two's complement, one per ref_clk edge
// Notes:   Flags are stretched by a hold counter restarted on every crossing
`timescale 1ns/1ps
module ovr_flag_unit (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Sample and settings
  input  wire logic [11:0] sample,
  input  wire logic [7:0]  thr_hi,
  input  wire logic [7:0]  thr_lo,
  input  wire logic [2:0]  hold_sel,
  // Results
  output logic      [1:0]  flag,
  output logic      [1:0]  hit
);

  typedef struct packed {
    logic [1:0][10:0] cnt;
    logic [1:0]       flag;
  } flag_state_s;

  flag_state_s      st;
  flag_state_s      next_st;
  logic      [11:0] neg;
  logic      [10:0] mag;
  logic      [7:0]  top8;
  logic      [10:0] hold;

  always_comb begin
    neg = 12'h000 - sample;
    if (sample == ovr_pkg::MOST_NEG) begin
      mag = ovr_pkg::MAG_MAX;
    end else if (sample[11]) begin
      mag = neg[10:0];
    end else begin
      mag = sample[10:0];
    end
    top8 = mag[10:3];
    hold = 11'(ovr_pkg::HOLD_BASE << hold_sel);
    hit[0] = (top8 >= thr_hi);
    hit[1] = (top8 >= thr_lo);
    next_st = st;
    for (int i = 0; i < 2; i++) begin
      if (hit[i]) begin
        next_st.cnt[i] = hold - 11'h001;
        next_st.flag[i] = 1'b1;
      end else begin
        next_st.flag[i] = (st.cnt[i] != 11'h000);
        if (st.cnt[i] != 11'h000) begin
          next_st.cnt[i] = st.cnt[i] - 11'h001;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag = st.flag;

  flag_on_hit_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    hit[0] |=> flag[0])
    else $error("flag did not rise after a crossing");

  saturate_mag_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (sample == ovr_pkg::MOST_NEG) |-> (top8 == 8'hFF))
    else $error("most negative code not saturated");

  hold_min8_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (hit[1] && hold_sel == 3'h0) ##1 (!hit[1] && hold_sel == 3'h0) [*8]
      |-> flag[1] ##1 !flag[1])
    else $error("shortest hold is not eight cycles");

endmodule

// ---- ovr_marker_top.sv ----
// Purpose: Overrange flags, sample marker, dither removal and frame strobe
// Assumes: One device clock for all logic; marker and sysref are asynchronous
// Notes:   Registers reached over classic Wishbone, single-cycle acknowledge
//
// Functional notes
// - Compare upper eight magnitude bits against thresholds
// - Magnitude saturates at 2047 for most negative
// - One threshold pair shared by both channels
// - Flag high when magnitude reaches threshold
// - Each channel drives two flags, index per threshold
// - Single mode splits each threshold over both sides; here the dual bit changes nothing and each side always flags on its own
// - Hold is eight shifted left by select
// - Marker replaces LSB with core-matched latency
// - Asynchronous marker sampled with its sample
// - Select sysref as marker source
// - Dual rising edges; single both edges; here both sides sample on rising edges only in either mode
// - Device clock drives all logic and outputs
// - Sysref resets dividers and strobe generator
// - Added dither removed before output
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module ovr_marker_top (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Converter samples and dither
  input  wire logic [11:0] raw_a,
  input  wire logic [11:0] raw_b,
  input  wire logic [11:0] dither_a,
  input  wire logic [11:0] dither_b,
  // Asynchronous timing inputs
  input  wire logic        marker_input,
  input  wire logic        sysref,
  // Sample outputs and strobes
  output logic      [11:0] out_a,
  output logic      [11:0] out_b,
  output logic             frame_strobe,
  output logic             div_clk,
  // Overrange flags and interrupt
  output logic             a_side_flag_zero,
  output logic             a_side_flag_one,
  output logic             b_side_flag_zero,
  output logic             b_side_flag_one,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic                 ack;
    logic [31:0]          rdat;
    logic                 marker_en;
    logic                 sr_marker;
    logic                 dual;
    logic [2:0]           hold_sel;
    logic [7:0]           thr_hi;
    logic [7:0]           thr_lo;
    logic [3:0]           lane_demux;
    logic [3:0]           frame_len;
    logic [4:0]           status;
    logic [4:0]           mask;
    logic [2:0]           mk_sync;
    logic                 mk;
    logic [2:0]           sr_sync;
    logic                 sr;
    logic [3:0][11:0]     dly_a;
    logic [3:0][11:0]     dly_b;
    logic [11:0]          out_a;
    logic [11:0]          out_b;
    logic [7:0]           frm_cnt;
    logic                 strobe;
    logic                 div_clk;
    logic                 irq;
  } top_state_s;

  top_state_s        st;
  top_state_s        next_st;
  logic       [1:0]  flag_a;
  logic       [1:0]  flag_b;
  logic       [1:0]  hit_a;
  logic       [1:0]  hit_b;
  logic       [11:0] clean_a;
  logic       [11:0] clean_b;
  logic       [7:0]  period;
  logic              sr_rise;
  logic              mark_bit;
  logic              req;
  logic       [31:0] wmask;
  logic       [31:0] img;
  logic       [31:0] wval;
  logic       [31:0] rd;
  logic       [4:0]  events;

  ////////////////////////////////////////////////////////////////////////////////
  // Overrange units, one per side

  // Same thresholds feed both sides
  // raw_a and raw_b are both taken on the rising edge in either mode; the dual bit does not change them
  ovr_flag_unit u_flag_a (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .sample   (clean_a),
    .thr_hi   (st.thr_hi),
    .thr_lo   (st.thr_lo),
    .hold_sel (st.hold_sel),
    .flag     (flag_a),
    .hit      (hit_a)
  );

  ovr_flag_unit u_flag_b (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .sample   (clean_b),
    .thr_hi   (st.thr_hi),
    .thr_lo   (st.thr_lo),
    .hold_sel (st.hold_sel),
    .flag     (flag_b),
    .hit      (hit_b)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;
    // Dither removed ahead of both the check and the output
    clean_a = raw_a - dither_a;
    clean_b = raw_b - dither_b;

    // Three-stage synchronisers; a change counts once stages two and three agree
    next_st.mk_sync = {st.mk_sync[1:0], marker_input};
    next_st.sr_sync = {st.sr_sync[1:0], sysref};
    if (st.mk_sync[1] == st.mk_sync[2]) begin
      next_st.mk = st.mk_sync[2];
    end
    if (st.sr_sync[1] == st.sr_sync[2]) begin
      next_st.sr = st.sr_sync[2];
    end
    sr_rise = next_st.sr & ~st.sr;

    // Sample delay matches the marker path latency
    next_st.dly_a = {st.dly_a[2:0], clean_a};
    next_st.dly_b = {st.dly_b[2:0], clean_b};
    mark_bit = st.sr_marker ? st.sr : st.mk;
    if (st.marker_en) begin
      next_st.out_a = {st.dly_a[3][11:1], mark_bit};
      next_st.out_b = {st.dly_b[3][11:1], mark_bit};
    end else begin
      next_st.out_a = st.dly_a[3];
      next_st.out_b = st.dly_b[3];
    end

    // Frame strobe and divider, restarted by a captured sysref
    period = 8'({4'h0, st.lane_demux} + 8'h01) * 8'((st.frame_len == 4'h0) ? 4'h1 : st.frame_len);
    next_st.strobe = 1'b0;
    if (sr_rise) begin
      next_st.frm_cnt = 8'h00;
      next_st.div_clk = 1'b0;
    end else begin
      next_st.div_clk = ~st.div_clk;
      if (st.frm_cnt >= period - 8'h01) begin
        next_st.frm_cnt = 8'h00;
        next_st.strobe = 1'b1;
      end else begin
        next_st.frm_cnt = st.frm_cnt + 8'h01;
      end
    end

    // Register images
    req = wb_cyc_i & wb_stb_i & ~st.ack;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    img = 32'h0000_0000;
    rd = 32'h0000_0000;
    if (wb_adr_i == ovr_pkg::CTRL_ADDR) begin
      img[ovr_pkg::CTRL_MARKER_EN] = st.marker_en;
      img[ovr_pkg::CTRL_SYSREF_MK] = st.sr_marker;
      img[ovr_pkg::CTRL_DUAL] = st.dual;
      img[ovr_pkg::CTRL_HOLD_LSB +: 3] = st.hold_sel;
      rd = img;
    end else if (wb_adr_i == ovr_pkg::THRESH_ADDR) begin
      img[ovr_pkg::THR_HI_LSB +: 8] = st.thr_hi;
      img[ovr_pkg::THR_LO_LSB +: 8] = st.thr_lo;
      rd = img;
    end else if (wb_adr_i == ovr_pkg::FRAME_ADDR) begin
      img[ovr_pkg::FRM_DEMUX_LSB +: 4] = st.lane_demux;
      img[ovr_pkg::FRM_LEN_LSB +: 4] = st.frame_len;
      rd = img;
    end else if (wb_adr_i == ovr_pkg::STATUS_ADDR) begin
      rd[ovr_pkg::ST_BITS-1:0] = st.status;
    end else if (wb_adr_i == ovr_pkg::MASK_ADDR) begin
      img[ovr_pkg::ST_BITS-1:0] = st.mask;
      rd = img;
    end else if (wb_adr_i == ovr_pkg::STATE_ADDR) begin
      rd[3:0] = {flag_b[1], flag_b[0], flag_a[1], flag_a[0]};
      rd[4] = st.mk;
      rd[ovr_pkg::STATE_CNT_LSB +: 8] = st.frm_cnt;
    end
    wval = (img & ~wmask) | (wb_dat_i & wmask);

    // Bus access
    next_st.ack = req;
    next_st.rdat = 32'h0000_0000;
    if (req && !wb_we_i) begin
      next_st.rdat = rd;
    end
    if (req && wb_we_i) begin
      if (wb_adr_i == ovr_pkg::CTRL_ADDR) begin
        next_st.marker_en = wval[ovr_pkg::CTRL_MARKER_EN];
        next_st.sr_marker = wval[ovr_pkg::CTRL_SYSREF_MK];
        next_st.dual = wval[ovr_pkg::CTRL_DUAL];
        next_st.hold_sel = wval[ovr_pkg::CTRL_HOLD_LSB +: 3];
      end else if (wb_adr_i == ovr_pkg::THRESH_ADDR) begin
        next_st.thr_hi = wval[ovr_pkg::THR_HI_LSB +: 8];
        next_st.thr_lo = wval[ovr_pkg::THR_LO_LSB +: 8];
      end else if (wb_adr_i == ovr_pkg::FRAME_ADDR) begin
        next_st.lane_demux = wval[ovr_pkg::FRM_DEMUX_LSB +: 4];
        next_st.frame_len = wval[ovr_pkg::FRM_LEN_LSB +: 4];
      end else if (wb_adr_i == ovr_pkg::MASK_ADDR) begin
        next_st.mask = wval[ovr_pkg::ST_BITS-1:0];
      end
    end

    // Sticky events: read clears, a new event in the same cycle wins
    events = {sr_rise, hit_b[1], hit_b[0], hit_a[1], hit_a[0]};
    if (req && !wb_we_i && wb_adr_i == ovr_pkg::STATUS_ADDR) begin
      next_st.status = events;
    end else begin
      next_st.status = st.status | events;
    end
    next_st.irq = |(next_st.status & next_st.mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  // Every register sits on the device clock; no second logic clock
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st <= '0;
      st.marker_en <= ovr_pkg::CTRL_RST[ovr_pkg::CTRL_MARKER_EN];
      st.sr_marker <= ovr_pkg::CTRL_RST[ovr_pkg::CTRL_SYSREF_MK];
      st.dual <= ovr_pkg::CTRL_RST[ovr_pkg::CTRL_DUAL];
      st.hold_sel <= ovr_pkg::CTRL_RST[ovr_pkg::CTRL_HOLD_LSB +: 3];
      st.thr_hi <= ovr_pkg::THRESH_RST[ovr_pkg::THR_HI_LSB +: 8];
      st.thr_lo <= ovr_pkg::THRESH_RST[ovr_pkg::THR_LO_LSB +: 8];
      st.lane_demux <= ovr_pkg::FRAME_RST[ovr_pkg::FRM_DEMUX_LSB +: 4];
      st.frame_len <= ovr_pkg::FRAME_RST[ovr_pkg::FRM_LEN_LSB +: 4];
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdat;
  assign out_a = st.out_a;
  assign out_b = st.out_b;
  assign frame_strobe = st.strobe;
  assign div_clk = st.div_clk;
  assign irq = st.irq;
  // Two flags per side, index follows the threshold
  assign a_side_flag_zero = flag_a[0];
  assign a_side_flag_one = flag_a[1];
  assign b_side_flag_zero = flag_b[0];
  assign b_side_flag_one = flag_b[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_one_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  bus_ack_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_bus_req |=> s_one_ack)
    else $error("acknowledge not a single cycle after request");

  marker_lsb_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st.marker_en && !st.sr_marker) |=> (out_a[0] == $past(st.mk)))
    else $error("marker bit missing from output LSB");

  sysref_mark_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st.marker_en && st.sr_marker) |=> (out_b[0] == $past(st.sr)))
    else $error("sysref not used as marker bit");

  marker_lat_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !st.marker_en |=> (out_a == $past(st.dly_a[3])))
    else $error("sample delay line broken");

  sysref_reset_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (next_st.sr && !st.sr) |=> (st.frm_cnt == 8'h00 && !div_clk && !frame_strobe))
    else $error("sysref did not restart divider");

  dither_out_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !st.marker_en |=> (out_a == $past(12'(raw_a - dither_a), 5)))
    else $error("dither left in output sample");

  irq_level_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    irq == |(st.status & st.mask))
    else $error("interrupt does not follow masked status");

  shared_thr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (clean_a == clean_b) |-> (hit_a == hit_b))
    else $error("channels compare against different thresholds");

endmodule

// ---- ovr_rx_model.sv ----
// Purpose: Downstream receiver of the overrange flags
// Assumes: Flags are levels registered on ref_clk
// Notes:   Merges both sides of each threshold as a single-channel receiver must
`timescale 1ns/1ps
module ovr_rx_model (
  // Clock
  input  wire logic ref_clk,
  // Flags from the converter
  input  wire logic fa0,
  input  wire logic fa1,
  input  wire logic fb0,
  input  wire logic fb1,
  // Merged threshold status
  output logic      over_hi,
  output logic      over_lo
);
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    over_hi = fa0 | fb0;
    over_lo = fa1 | fb1;
  end
endmodule

// ---- tb.sv ----
// Purpose: Self-checking bench for the overrange and marker block
// Assumes: The reference model follows the control and threshold writes of this bench
// Notes:   A flag is expected in the cycle after the edge that saw the crossing
`timescale 1ns/1ps
module tb;
  ////////////////////////////////////////////////////////////////////////////
  logic        ref_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, flg;
  logic [31:0] wb_dat_i, wb_dat_o, m_ctrl, m_thr, rd;
  logic [11:0] raw_a, raw_b, dither_a, dither_b, out_a, out_b, inj_a, inj_b;
  logic        marker_input, sysref, frame_strobe, div_clk, irq, over_hi, over_lo;
  logic        a_side_flag_zero, a_side_flag_one, b_side_flag_zero, b_side_flag_one;
  logic        mk_lv, sref_p, smode;
  logic [11:0] ch_a [2048];
  logic [11:0] ch_b [2048];
  logic        mk_h [2048];
  int          lh [4][2048];
  int          last [4];
  int          num_errors, checks_done, seed, k, skip, n, p;

  assign flg = {b_side_flag_one, b_side_flag_zero, a_side_flag_one, a_side_flag_zero};

  ovr_marker_top i_ovr_marker_top (.ref_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .raw_a, .raw_b, .dither_a,
    .dither_b, .marker_input, .sysref, .out_a, .out_b, .frame_strobe, .div_clk,
    .a_side_flag_zero, .a_side_flag_one, .b_side_flag_zero, .b_side_flag_one, .irq);

  ovr_rx_model i_ovr_rx_model (.ref_clk, .fa0(a_side_flag_zero), .fa1(a_side_flag_one),
    .fb0(b_side_flag_zero), .fb1(b_side_flag_one), .over_hi, .over_lo);

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] alt,
                     input logic [31:0] got);
    checks_done++;
    if (got !== ex && got !== alt) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [7:0] top8(input logic [11:0] s);
    logic [10:0] m;
    m = (s == ovr_pkg::MOST_NEG) ? 11'h7FF : (s[11] ? 11'(-s) : s[10:0]);
    return m[10:3];
  endfunction

  // Any hit within the hold span before the flag's sampling point
  function automatic logic fexp(input int i, input int e, input int d);
    int j;
    int v;
    j = e - d;
    v = (j < 0) ? -1 : lh[i][j % 2048];
    return v >= 0 && j - v < (8 << m_ctrl[6:4]);
  endfunction

  function automatic logic [11:0] pick();
    logic [31:0] r;
    r = $random(seed);
    case (r[5:0])
      0: return 12'h800;
      1: return {1'b0, m_thr[7:0], 3'h0};
      2: return -{1'b0, m_thr[15:8], 3'h7};
      3: return {1'b0, m_thr[7:0] - 8'h01, 3'h7};
      default: return {{7{r[10]}}, r[14:10]};
    endcase
  endfunction

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int t;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    if (t >= 50) begin
      num_errors++;
      $display("[FAIL] wb_ack_o expected 1 seen 0");
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (we && a == ovr_pkg::CTRL_ADDR) m_ctrl = d;
    if (we && a == ovr_pkg::THRESH_ADDR) begin
      for (int b = 0; b < 2; b++) if (s[b]) m_thr[8*b +: 8] = d[8*b +: 8];
    end
    if (we) skip = (a == ovr_pkg::CTRL_ADDR) ? 1044 : 4;
  endtask

  task automatic inject(input logic [11:0] a, input logic [11:0] b);
    @(posedge ref_clk);
    inj_a <= a;
    inj_b <= b;
    @(posedge ref_clk);
    inj_a <= 12'h000;
    inj_b <= 12'h000;
    repeat (12) @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus stream: raw carries the chosen clean sample plus dither
  always @(posedge ref_clk) begin
    logic [11:0] da;
    logic [11:0] db;
    da = 12'($random(seed));
    db = 12'($random(seed));
    if (($random(seed) & 15) == 0) mk_lv = ~mk_lv;
    dither_a <= da;
    dither_b <= db;
    raw_a <= (smode ? pick() : inj_a) + da;
    raw_b <= (smode ? pick() : inj_b) + db;
    marker_input <= mk_lv;
    sysref <= (smode && m_ctrl[1]) ? mk_lv : sref_p;
  end

  // Reference model: records what each edge sampled
  always @(posedge ref_clk) begin
    if (skip > 0) skip--;
    ch_a[k % 2048] = raw_a - dither_a;
    ch_b[k % 2048] = raw_b - dither_b;
    mk_h[k % 2048] = m_ctrl[1] ? sysref : marker_input;
    for (int i = 0; i < 4; i++) begin
      if (!rstn) last[i] = -1;
      else if (top8(i < 2 ? raw_a - dither_a : raw_b - dither_b) >= m_thr[(i%2)*8 +: 8])
        last[i] = k;
      lh[i][k % 2048] = last[i];
    end
    k++;
  end

  always @(negedge ref_clk) begin
    int e;
    logic [11:0] msk;
    logic [11:0] ea;
    logic [11:0] eb;
    logic        hi;
    logic        lo;
    e = k - 1;
    msk = 12'hFFF;
    if (rstn && skip == 0 && e > 8) begin
      ea = ch_a[(e - 4) % 2048];
      eb = ch_b[(e - 4) % 2048];
      if (m_ctrl[0]) begin
        ea[0] = mk_h[(e - 4) % 2048];
        eb[0] = ea[0];
        for (int j = 2; j < 7; j++) if (mk_h[(e - j) % 2048] != ea[0]) msk = 12'hFFE;
      end
      chk("out_a", 32'(ea & msk), 32'(ea & msk), 32'(out_a & msk));
      chk("out_b", 32'(eb & msk), 32'(eb & msk), 32'(out_b & msk));
      for (int i = 0; i < 4; i++)
        chk("flag", 32'(fexp(i, e, 0)), 32'(fexp(i, e, 0)), 32'(flg[i]));
      hi = fexp(0, e, 0) | fexp(2, e, 0);
      lo = fexp(1, e, 0) | fexp(3, e, 0);
      chk("merged hi", 32'(hi), 32'(hi), 32'(over_hi));
      chk("merged lo", 32'(lo), 32'(lo), 32'(over_lo));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0]  ra [4];
    logic [31:0] rv [4];
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, marker_input, sysref, mk_lv, sref_p, smode} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, raw_a, raw_b, dither_a, dither_b, inj_a, inj_b} = '0;
    seed = 32'h08f7;
    m_ctrl = ovr_pkg::CTRL_RST;
    m_thr = ovr_pkg::THRESH_RST;
    skip = 24;
    ra = '{ovr_pkg::CTRL_ADDR, ovr_pkg::THRESH_ADDR, ovr_pkg::FRAME_ADDR, ovr_pkg::MASK_ADDR};
    rv = '{ovr_pkg::CTRL_RST, ovr_pkg::THRESH_RST, ovr_pkg::FRAME_RST, 32'h0};
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, ra[i], 32'h0, 4'hF, rd);
      chk("reset value", rv[i], rv[i], rd);
    end
    wb(1'b1, 8'h40, 32'hFFFF_FFFF, 4'hF, rd);
    wb(1'b0, 8'h40, 32'h0, 4'hF, rd);
    chk("unmapped", 32'h0, 32'h0, rd);
    wb(1'b1, ovr_pkg::THRESH_ADDR, 32'h0000_1234, 4'h1, rd);
    wb(1'b0, ovr_pkg::THRESH_ADDR, 32'h0, 4'hF, rd);
    chk("byte select", 32'h0000_FF34, 32'h0000_FF34, rd);
    // Sticky status, mask and interrupt
    wb(1'b1, ovr_pkg::THRESH_ADDR, 32'h0000_40E4, 4'hF, rd);
    wb(1'b1, ovr_pkg::MASK_ADDR, 32'h0000_000F, 4'hF, rd);
    wb(1'b0, ovr_pkg::STATUS_ADDR, 32'h0, 4'hF, rd);
    wb(1'b0, ovr_pkg::STATUS_ADDR, 32'h0, 4'hF, rd);
    chk("status idle", 32'h0, 32'h0, rd);
    inject(ovr_pkg::MOST_NEG, 12'h000);
    chk("irq set", 32'h1, 32'h1, 32'(irq));
    wb(1'b0, ovr_pkg::STATUS_ADDR, 32'h0, 4'hF, rd);
    chk("status a", 32'h3, 32'h3, rd);
    repeat (3) @(posedge ref_clk);
    chk("irq clear", 32'h0, 32'h0, 32'(irq));
    wb(1'b1, ovr_pkg::MASK_ADDR, 32'h0000_0001, 4'hF, rd);
    inject(12'h000, 12'h320);
    chk("irq masked", 32'h0, 32'h0, 32'(irq));
    wb(1'b0, ovr_pkg::STATUS_ADDR, 32'h0, 4'hF, rd);
    chk("status b", 32'h8, 32'h8, rd);
    // Frame strobe period and resynchronisation
    for (int f = 0; f < 2; f++) begin
      wb(1'b1, ovr_pkg::FRAME_ADDR, f ? 32'h0000_0002 : 32'h0000_0301, 4'hF, rd);
      p = f ? 3 : 6;
      @(posedge ref_clk);
      sref_p <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sref_p <= 1'b0;
      repeat (10) @(posedge ref_clk);
      n = 0;
      while (frame_strobe !== 1'b1 && n < 40) begin
        @(posedge ref_clk);
        n++;
      end
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (frame_strobe !== 1'b1 && n < 40);
      chk("strobe period", p, p, n);
      chk("div_clk phase", 32'h0, 32'h0, 32'(div_clk));
      wb(1'b0, ovr_pkg::STATUS_ADDR, 32'h0, 4'hF, rd);
      chk("sysref status", 32'h10, 32'h10, rd);
    end
    // Every hold select with marker, source and mode settings
    smode <= 1'b1;
    for (int h = 0; h < 8; h++) begin
      wb(1'b1, ovr_pkg::THRESH_ADDR, $random(seed) & 32'h0000_FFFF, 4'hF, rd);
      wb(1'b1, ovr_pkg::CTRL_ADDR, 32'((h << 4) | h), 4'hF, rd);
      repeat (1500) @(posedge ref_clk);
    end
    smode <= 1'b0;
    print_verdict();
  end

  initial begin
    #200000;
    num_errors++;
    $display("[FAIL] run time expected below limit seen timeout");
    print_verdict();
  end
endmodule
